// >>> inc/load_readout_cfg.svh
/*
 * Offsets, field positions, reset values and timing constants of the
 * load measurement readout block.
 * Assumes word addressing on the plain register port of the device.
 */
`ifndef LOAD_READOUT_CFG_SVH
`define LOAD_READOUT_CFG_SVH

// ****************************************************************
// register offsets (word addresses)
// ****************************************************************
`define ADDR_THRESHOLD        8'h74
`define ADDR_LOAD_RESULT      8'h75
`define ADDR_HISTORY          8'h76
`define ADDR_IRQ_STATUS       8'h77
`define ADDR_IRQ_ENABLE       8'h78
`define ADDR_IRQ_CLEAR        8'h79

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define THR_FILTER_EN_BIT     8
`define THR_ANGLE_OFS_BIT     9
`define THR_RESET_VALUE       32'h0000_0200
`define RESULT_RESET_VALUE    10'h000
`define HISTORY_RESET_VALUE   32'h0000_0000
`define IRQ_BIT_RESULT        0
`define IRQ_BIT_STALL         1
`define IRQ_WIDTH             2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS         50

`endif

// >>> inc/load_readout_pkg.sv
/*
 * Types shared by the load measurement readout block.
 * Assumes the constants header is compiled alongside.
 */
package load_readout_pkg;

    // ****************************************************************
    // register bus request
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // ****************************************************************
    // filter history, newest in the lowest byte
    // ****************************************************************
    typedef struct packed {
        logic [7:0] prev3;
        logic [7:0] prev2;
        logic [7:0] prev1;
        logic [7:0] newest;
    } history_t;

    // ****************************************************************
    // capture sequencer states, gray ordered
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_COMPARE = 2'b11
    } cap_state_t;

endpackage

// >>> design/stall_compare.sv
/*
 * Stall comparison of the 10-bit load result against twice the
 * 8-bit threshold, registered.
 * Assumes one clock and the asynchronous active-low device reset.
 */
`timescale 1ns/1ps
`include "load_readout_cfg.svh"

module stall_compare
#(
    parameter int RES_W = 10,
    parameter int THR_W = 8
)
(
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             compare_en,
    input  wire logic [RES_W-1:0] result_in,
    input  wire logic [THR_W-1:0] threshold_in,
    output logic                  stall_ff
);

    logic [RES_W-1:0] doubled;
    logic             nxt_stall;

    // ****************************************************************
    // comparison
    // ****************************************************************
    // threshold widened first so the shift never drops the top bit
    assign doubled   = {{(RES_W-THR_W-1){1'b0}}, threshold_in, 1'b0};
    assign nxt_stall = (result_in <= doubled);

    // held between comparisons so a stall stays visible for a whole step
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            stall_ff <= 1'b0;
        else if (compare_en)
            stall_ff <= nxt_stall;
    end

endmodule

// >>> design/stall_load_measurement_readout.sv
/*
 * Load measurement readout of one motor axis: per full step load
 * result, four byte raw measurement history, stall flag output and the
 * threshold register with filter enable, the registers on a plain register port.
 * Assumes full_step is a one-cycle pulse synchronous to core_clk and
 * raw_measurement carries a valid sample in that cycle, with larger
 * values for a lighter load.
 */
// Overview of operation
// - the load result refreshes once on every full step pulse and never otherwise.
// - the refresh ignores the velocity threshold and the stall threshold.
// - a lighter load gives a larger result, passed straight from the raw measurement.
// - result bits 9 and 0 always read zero, the 8-bit value sits in bits 8:1.
// - the result register is read only, resets to zero and holds only the newer method.
// - with the filter on, measurements 3, 2, 1 show in bytes 31:24, 23:16, 15:8.
// - byte 7:0 always shows the current raw measurement, measurement 0 of the filter.
// - all four history bytes are read only and reset to zero.
// - bit 8 of the threshold register turns the filter on when one, off when zero.
// - a stall is flagged when the result does not exceed twice the threshold.
`timescale 1ns/1ps
`include "load_readout_cfg.svh"

module stall_load_measurement_readout
    import load_readout_pkg::*;
#(
    parameter int MEAS_W = 8,
    parameter int RES_W  = 10
)
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata_ff,
    input  wire logic              full_step,
    input  wire logic [MEAS_W-1:0] raw_measurement,
    input  wire logic              current_scaling_velocity_threshold_hit,
    output logic                   stall_flag_ff,
    output logic                   load_filter_enable_ff,
    output logic                   irq_ff
);

    reg_req_t                 req;
    cap_state_t               state_ff;
    cap_state_t               nxt_state;
    logic [MEAS_W-1:0]        sample_ff;
    logic [RES_W-1:0]         load_result_value_ff;
    history_t                 history_ff;
    logic [MEAS_W-1:0]        stall_threshold_ff;
    logic                     angle_offset_ff;
    logic                     stall_cmp;
    logic [`IRQ_WIDTH-1:0]    irq_status_ff;
    logic [`IRQ_WIDTH-1:0]    irq_enable_ff;
    logic [`IRQ_WIDTH-1:0]    irq_event;
    logic [`IRQ_WIDTH-1:0]    irq_clear;
    logic                     stall_rise;
    logic                     stall_prev_ff;
    logic [31:0]              nxt_rdata;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ****************************************************************
    // capture sequencer
    // ****************************************************************
    // step pulse latches the sample, next cycle updates, then compares;
    // a new step during the sequence restarts it so none is dropped
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:    nxt_state = full_step ? ST_CAPTURE : ST_IDLE;
            ST_CAPTURE: nxt_state = full_step ? ST_CAPTURE : ST_COMPARE;
            ST_COMPARE: nxt_state = full_step ? ST_CAPTURE : ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            sample_ff <= '0;
        else if (full_step)
            sample_ff <= raw_measurement;
    end

    // ****************************************************************
    // load result
    // ****************************************************************
    // update once per step
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            load_result_value_ff <= `RESULT_RESET_VALUE;
        else if (state_ff == ST_CAPTURE)
            load_result_value_ff <= {1'b0, sample_ff, 1'b0};
    end

    // ****************************************************************
    // measurement history
    // ****************************************************************
    // newest byte always live
    // shift history up
    // the upper bytes freeze while the filter is off, holding the last window
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            history_ff <= `HISTORY_RESET_VALUE;
        else if (state_ff == ST_CAPTURE)
        begin
            history_ff.newest <= sample_ff;
            if (load_filter_enable_ff)
            begin
                history_ff.prev1 <= history_ff.newest;
                history_ff.prev2 <= history_ff.prev1;
                history_ff.prev3 <= history_ff.prev2;
            end
        end
    end

    // ****************************************************************
    // threshold register
    // ****************************************************************
    // filter enable bit
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stall_threshold_ff    <= MEAS_W'(`THR_RESET_VALUE);
            load_filter_enable_ff <= 1'(`THR_RESET_VALUE >> `THR_FILTER_EN_BIT);
            angle_offset_ff       <= 1'(`THR_RESET_VALUE >> `THR_ANGLE_OFS_BIT);
        end
        else if (req.wr && req.addr == `ADDR_THRESHOLD)
        begin
            stall_threshold_ff    <= req.wdata[MEAS_W-1:0];
            load_filter_enable_ff <= req.wdata[`THR_FILTER_EN_BIT];
            angle_offset_ff       <= req.wdata[`THR_ANGLE_OFS_BIT];
        end
    end

    // ****************************************************************
    // stall detection
    // ****************************************************************
    // compare after update
    stall_compare #(
        .RES_W        (RES_W),
        .THR_W        (MEAS_W)
    ) i_stall_compare (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .compare_en   (state_ff == ST_COMPARE),
        .result_in    (load_result_value_ff),
        .threshold_in (stall_threshold_ff),
        .stall_ff     (stall_cmp)
    );

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stall_flag_ff <= 1'b0;
            stall_prev_ff <= 1'b0;
        end
        else
        begin
            stall_flag_ff <= stall_cmp;
            stall_prev_ff <= stall_cmp;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    assign stall_rise = stall_cmp & ~stall_prev_ff;
    assign irq_event  = {stall_rise, (state_ff == ST_CAPTURE)};
    assign irq_clear  = (req.wr && req.addr == `ADDR_IRQ_CLEAR) ? req.wdata[`IRQ_WIDTH-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_status_ff <= '0;
        else
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_enable_ff <= '0;
        else if (req.wr && req.addr == `ADDR_IRQ_ENABLE)
            irq_enable_ff <= req.wdata[`IRQ_WIDTH-1:0];
    end

    // registered from the next status value, so it changes in the same cycle as status
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(((irq_status_ff & ~irq_clear) | irq_event) & irq_enable_ff);
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // result read only
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (req.addr)
            `ADDR_THRESHOLD:   nxt_rdata = {22'h0, angle_offset_ff, load_filter_enable_ff, stall_threshold_ff};
            `ADDR_LOAD_RESULT: nxt_rdata = {22'h0, load_result_value_ff};
            `ADDR_HISTORY:     nxt_rdata = history_ff;
            `ADDR_IRQ_STATUS:  nxt_rdata = {30'h0, irq_status_ff};
            `ADDR_IRQ_ENABLE:  nxt_rdata = {30'h0, irq_enable_ff};
            default:           nxt_rdata = 32'h0000_0000;
        endcase
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata_ff <= 32'h0000_0000;
        else if (req.rd)
            reg_rdata_ff <= nxt_rdata;
        else
            reg_rdata_ff <= 32'h0000_0000;
    end

endmodule

// >>> testbench/stall_readout_properties.sv
/*
 * Port checker of the load measurement readout block.
 * Assumes it is bound to the top module, with the register map of the constants header.
 */
`timescale 1ns/1ps
`include "load_readout_cfg.svh"

module stall_readout_checker
#(
    parameter int MEAS_W = 8
)
(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata_ff,
    input wire logic              full_step,
    input wire logic [MEAS_W-1:0] raw_measurement,
    input wire logic              stall_flag_ff,
    input wire logic              load_filter_enable_ff
);
    logic [7:0] thr_ff;
    logic       thr_wr;

    // shadow of the threshold field, so the stall figure is checked end to end
    assign thr_wr = reg_wr && reg_addr == `ADDR_THRESHOLD;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            thr_ff <= 8'h00;
        else if (thr_wr)
            thr_ff <= reg_wdata[7:0];
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // ****************************************************************
    // register port and results
    // ****************************************************************
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata_ff == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside its slot");
    property p_unmapped;
        $past(reg_rd) && !($past(reg_addr) inside {[8'h74:8'h78]}) |-> reg_rdata_ff == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped or clear read not zero");
    property p_result_bits;
        $past(reg_rd) && $past(reg_addr) == `ADDR_LOAD_RESULT |-> reg_rdata_ff[31:9] == 23'h0 && !reg_rdata_ff[0];
    endproperty
    a_result_bits: assert property (p_result_bits)
        else $error("load result padding bits not zero");
    property p_result_step;
        full_step ##1 !full_step ##1 (reg_rd && reg_addr == `ADDR_LOAD_RESULT)
        |=> reg_rdata_ff[8:1] == $past(raw_measurement, 3);
    endproperty
    a_result_step: assert property (p_result_step)
        else $error("load result not the last sample");
    property p_history_low;
        full_step ##1 !full_step ##1 (reg_rd && reg_addr == `ADDR_HISTORY)
        |=> reg_rdata_ff[7:0] == $past(raw_measurement, 3);
    endproperty
    a_history_low: assert property (p_history_low)
        else $error("history low byte not the last sample");

    // ****************************************************************
    // filter enable and stall flag
    // ****************************************************************
    property p_filter_en;
        thr_wr |=> load_filter_enable_ff == $past(reg_wdata[8]);
    endproperty
    a_filter_en: assert property (p_filter_en)
        else $error("filter enable not taken from bit 8");
    property p_filter_hold;
        !thr_wr |=> $stable(load_filter_enable_ff);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("filter enable moved without a write");
    property p_stall;
        full_step ##1 !full_step [*3]
        |=> stall_flag_ff == ({1'b0, $past(raw_measurement, 4), 1'b0} <= {1'b0, thr_ff, 1'b0});
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall flag disagrees with twice the threshold");
    property p_stall_cause;
        $changed(stall_flag_ff) |-> $past(full_step, 4);
    endproperty
    a_stall_cause: assert property (p_stall_cause)
        else $error("stall flag moved without a full step");
endmodule

bind stall_load_measurement_readout stall_readout_checker #(.MEAS_W(MEAS_W)) i_stall_readout_checker (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .full_step(full_step),
    .raw_measurement(raw_measurement), .stall_flag_ff(stall_flag_ff),
    .load_filter_enable_ff(load_filter_enable_ff));

// >>> testbench/stall_load_measurement_readout_bench.sv
/*
 * Register level bench of the load measurement readout block.
 * Assumes the checker file is compiled beside it and binds itself.
 */
`timescale 1ns/1ps
`include "load_readout_cfg.svh"

module stall_load_measurement_readout_bench;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata_ff;
    logic        full_step = 1'b0;
    logic [7:0]  raw_measurement = 8'h00;
    logic        vel_hit = 1'b0;
    logic        stall_flag_ff;
    logic        load_filter_enable_ff;
    logic        irq_ff;
    int          miscompares = 0;
    int          checks_done = 0;

    // 20 MHz core clock
    always #(`CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    stall_load_measurement_readout i_stall_load_measurement_readout (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .full_step(full_step),
        .raw_measurement(raw_measurement), .current_scaling_velocity_threshold_hit(vel_hit),
        .stall_flag_ff(stall_flag_ff), .load_filter_enable_ff(load_filter_enable_ff), .irq_ff(irq_ff));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // let the written register settle before a caller looks at an output
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_ff;
    endtask

    // sample line is inverted after the pulse so a stale value cannot pass
    task automatic step(input logic [7:0] v);
        @(posedge core_clk);
        full_step <= 1'b1;
        raw_measurement <= v;
        @(posedge core_clk);
        full_step <= 1'b0;
        raw_measurement <= ~v;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog far beyond the roughly one hundred cycles the tests need
    initial
    begin
        #(`CLK_PERIOD_NS * 5000);
        miscompares++;
        end_of_test();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        logic [31:0] d;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        rd(`ADDR_LOAD_RESULT, d); chk(d, 32'h0);
        rd(`ADDR_HISTORY, d); chk(d, `HISTORY_RESET_VALUE);
        rd(`ADDR_THRESHOLD, d); chk(d, `THR_RESET_VALUE);
        wr(`ADDR_LOAD_RESULT, 32'hFFFF_FFFF);
        wr(`ADDR_HISTORY, 32'hFFFF_FFFF);
        rd(`ADDR_LOAD_RESULT, d); chk(d, 32'h0);
        rd(`ADDR_HISTORY, d); chk(d, 32'h0);
        rd(8'h7F, d); chk(d, 32'h0);
        $display("reset and read-only test done");
        step(8'hA5);
        rd(`ADDR_LOAD_RESULT, d); chk(d, 32'h14A);
        rd(`ADDR_HISTORY, d); chk(d, 32'hA5);
        @(posedge core_clk);
        vel_hit <= 1'b1;
        wr(`ADDR_THRESHOLD, 32'h2FF);
        rd(`ADDR_LOAD_RESULT, d); chk(d, 32'h14A);
        step(8'h3C);
        rd(`ADDR_LOAD_RESULT, d); chk(d, 32'h78);
        $display("refresh test done");
        wr(`ADDR_THRESHOLD, 32'h300);
        chk(load_filter_enable_ff, 1'b1);
        for (int i = 1; i <= 4; i++)
            step(8'(8'h11 * i));
        rd(`ADDR_HISTORY, d); chk(d, 32'h1122_3344);
        wr(`ADDR_THRESHOLD, 32'h200);
        chk(load_filter_enable_ff, 1'b0);
        step(8'h55);
        rd(`ADDR_HISTORY, d); chk(d, 32'h1122_3355);
        $display("filter history test done");
        wr(`ADDR_THRESHOLD, 32'h240);
        step(8'h40);
        cyc(4); chk(stall_flag_ff, 1'b1);
        step(8'h41);
        cyc(4); chk(stall_flag_ff, 1'b0);
        $display("stall test done");
        wr(`ADDR_IRQ_CLEAR, 32'h3);
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        rd(`ADDR_IRQ_ENABLE, d); chk(d, 32'h1);
        step(8'h80);
        cyc(3); chk(irq_ff, 1'b1);
        rd(`ADDR_IRQ_STATUS, d); chk(d, 32'h1);
        wr(`ADDR_IRQ_CLEAR, 32'h1);
        cyc(1); chk(irq_ff, 1'b0);
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        step(8'h10);
        cyc(5); chk(irq_ff, 1'b0);
        rd(`ADDR_IRQ_STATUS, d); chk(d, 32'h3);
        wr(`ADDR_IRQ_ENABLE, 32'h2);
        cyc(1); chk(irq_ff, 1'b1);
        rd(`ADDR_IRQ_CLEAR, d); chk(d, 32'h0);
        $display("interrupt test done");
        end_of_test();
    end
endmodule
